/* File: acd_consts.vh */
/*
 * Constants for the ADC command byte decoder: field positions,
 * reset values and encodings of the setup byte.
 * Assumes inclusion by bare name from the design files and the bench.
 */
`ifndef ACD_CONSTS_VH
`define ACD_CONSTS_VH

// Setup byte field positions
`define ACD_CLK_HI_BIT      5
`define ACD_CLK_LO_BIT      4
`define ACD_REF_HI_BIT      3
`define ACD_REF_LO_BIT      2
`define ACD_PAIR_HI_BIT     1
`define ACD_PAIR_LO_BIT     0
// Averaging byte field position
`define ACD_AVG_EN_BIT      4
// Reset byte choice bit
`define ACD_RST_CHOICE_BIT  3

// Power-up values
`define ACD_CFG_RESET       8'h20
`define ACD_PAIR_RESET      8'h00
`define ACD_AVG_RESET       8'h00
`define ACD_CONV_RESET      8'h00

// Clock modes
`define ACD_CLK_INT_INT     2'h0
`define ACD_CLK_INT_STROBE  2'h1
`define ACD_CLK_INT_AIN     2'h2
`define ACD_CLK_EXT_SCLK    2'h3

// Reference modes
`define ACD_REF_INT_AUTO    2'h0
`define ACD_REF_EXT_SE      2'h1
`define ACD_REF_INT_ON      2'h2
`define ACD_REF_EXT_DIFF    2'h3

// Pair register select codes
`define ACD_PAIR_UNI        2'h2
`define ACD_PAIR_BI         2'h3

// Scan modes
`define ACD_SCAN_REPEAT     2'h2

// Temperature: eighth degrees; Kelvin to Celsius offset 273 K * 8
`define ACD_TEMP_OFFSET     12'h888

// Output word layout
`define ACD_WORD_BITS       16

// Serial clock limit in clock mode 11, kHz
`define ACD_EXT_SCLK_MAX_KHZ 4800

`endif

/* File: acd_shift_reg.v */
/*
 * Output word shifter: loads a 16-bit result word and presents it MSB
 * first, one bit per falling serial clock edge.
 * Assumes load and shift strobes are single sys_clk pulses.
 */
`timescale 1ns/10ps
`default_nettype none
`include "acd_consts.vh"

module acd_shift_reg #(
	parameter WIDTH = `ACD_WORD_BITS
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             rst,
	// Control
	input  wire             load,
	input  wire             shift,
	input  wire [WIDTH-1:0] word_in,
	// Serial output
	output wire             bit_out
);

	reg [WIDTH-1:0] word_reg;

	// Load wins over shift so a fresh word never loses its top bit
	always @(posedge sys_clk) begin
		if (rst) begin
			word_reg <= {WIDTH{1'b0}};
		end else if (load) begin
			word_reg <= word_in;
		end else if (shift) begin
			word_reg <= {word_reg[WIDTH-2:0], 1'b0};
		end
	end

	assign bit_out = word_reg[WIDTH-1];

endmodule // acd_shift_reg

`default_nettype wire

/* File: acd_decoder.v */
/*
 * Command byte decoder and configuration state of a multi-channel ADC.
 * Receives bytes on the serial port, holds setup, pair, averaging and
 * conversion settings, and formats result words for shifting out.
 * Assumes the serial pins arrive asynchronously to sys_clk and that the
 * serial clock is far slower than sys_clk (bench: 320 ns period).
 */
`timescale 1ns/10ps
`default_nettype none
`include "acd_consts.vh"

module acd_decoder (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// Serial pins
	input  wire        cs_n,
	input  wire        sclk,
	input  wire        din,
	output wire        dout,
	// Conversion strobe pin (top analog input in modes 10 and 11)
	input  wire        convert_strobe_pin,
	// Results from the analog core
	input  wire        conv_done,
	input  wire [9:0]  conv_code,
	input  wire [1:0]  conv_sub,
	input  wire [11:0] temp_high,
	input  wire [11:0] temp_low,
	input  wire        temp_done,
	// Configuration outputs
	output reg  [1:0]  clock_mode,
	output reg  [1:0]  reference_mode,
	output reg         external_conv_clock,
	output reg         strobe_is_analog,
	output reg         ref_neg_is_analog,
	output reg         ref_internal,
	output reg         ref_always_on,
	output reg         ref_wake_needed,
	output reg  [7:0]  unipolar_pairs,
	output reg  [7:0]  bipolar_pairs,
	output reg  [7:0]  pair_is_bipolar,
	output reg         averaging_active,
	output reg         repeat_single_channel,
	output reg  [7:0]  conversion_byte,
	output reg         conversion_request,
	output reg         fifo_clear,
	output reg         blocks_shutdown,
	output reg         strobe_fall
);

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	reg [1:0] cs_sync_reg;
	reg [1:0] sclk_sync_reg;
	reg [1:0] din_sync_reg;
	reg [1:0] strobe_sync_reg;
	reg       sclk_last_reg;
	reg       strobe_last_reg;

	// Two flops per pin; only the second stage feeds logic
	always @(posedge sys_clk) begin
		if (rst) begin
			cs_sync_reg     <= 2'h3;
			sclk_sync_reg   <= 2'h0;
			din_sync_reg    <= 2'h0;
			strobe_sync_reg <= 2'h3;
			sclk_last_reg   <= 1'b0;
			strobe_last_reg <= 1'b1;
		end else begin
			cs_sync_reg     <= {cs_sync_reg[0], cs_n};
			sclk_sync_reg   <= {sclk_sync_reg[0], sclk};
			din_sync_reg    <= {din_sync_reg[0], din};
			strobe_sync_reg <= {strobe_sync_reg[0], convert_strobe_pin};
			sclk_last_reg   <= sclk_sync_reg[1];
			strobe_last_reg <= strobe_sync_reg[1];
		end
	end

	wire cs_active = ~cs_sync_reg[1];
	wire sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;
	wire sclk_fall = ~sclk_sync_reg[1] & sclk_last_reg;
	wire din_s     = din_sync_reg[1];

	// ---------------------------------------------------------------
	// Byte assembly
	// ---------------------------------------------------------------
	reg [6:0] shift_reg;
	reg [2:0] bit_cnt_reg;
	reg       byte_valid;
	reg [7:0] byte_data;

	// Bits enter MSB first on rising serial edges; deselect drops a
	// partial byte so a new frame always starts aligned
	always @(posedge sys_clk) begin
		if (rst || !cs_active) begin
			shift_reg   <= 7'h00;
			bit_cnt_reg <= 3'h0;
			byte_valid  <= 1'b0;
			byte_data   <= 8'h00;
		end else begin
			byte_valid <= 1'b0;
			if (sclk_rise) begin
				shift_reg   <= {shift_reg[5:0], din_s};
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7) begin
					byte_data  <= {shift_reg, din_s};
					byte_valid <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	localparam [2:0] CMD_NONE  = 3'h0;
	localparam [2:0] CMD_CONV  = 3'h1;
	localparam [2:0] CMD_SETUP = 3'h2;
	localparam [2:0] CMD_AVG   = 3'h3;
	localparam [2:0] CMD_RESET = 3'h4;

	// Command type is the position of the first one among the top bits
	function [2:0] cmd_type;
		input [7:0] b;
		begin
			if (b[7])
				cmd_type = CMD_CONV;
			else if (b[6])
				cmd_type = CMD_SETUP;
			else if (b[5])
				cmd_type = CMD_AVG;
			else if (b[4])
				cmd_type = CMD_RESET;
			else
				cmd_type = CMD_NONE;
		end
	endfunction

	wire [2:0] cmd = cmd_type(byte_data);

	// ---------------------------------------------------------------
	// Byte sequencer: command byte or pending pair data byte
	// ---------------------------------------------------------------
	localparam [1:0] ST_CMD     = 2'h0;
	localparam [1:0] ST_UNI_DAT = 2'h1;
	localparam [1:0] ST_BI_DAT  = 2'h2;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [7:0] cfg_reg;
	reg [7:0] uni_reg;
	reg [7:0] bi_reg;
	reg [7:0] avg_reg;
	reg [7:0] conv_reg;
	reg       full_reset;
	reg       fifo_reset;

	// Next state and reset requests from the current byte
	always @* begin
		state_next = state_reg;
		full_reset = 1'b0;
		fifo_reset = 1'b0;
		if (byte_valid) begin
			case (state_reg)
			ST_UNI_DAT, ST_BI_DAT: begin
				state_next = ST_CMD;
			end
			ST_CMD: begin
				if (cmd == CMD_SETUP) begin
					case (byte_data[`ACD_PAIR_HI_BIT:`ACD_PAIR_LO_BIT])
					`ACD_PAIR_UNI: state_next = ST_UNI_DAT;
					`ACD_PAIR_BI:  state_next = ST_BI_DAT;
					default:       state_next = ST_CMD;
					endcase
				end else if (cmd == CMD_RESET) begin
					fifo_reset = byte_data[`ACD_RST_CHOICE_BIT];
					full_reset = ~byte_data[`ACD_RST_CHOICE_BIT];
				end
			end
			default: begin
				state_next = ST_CMD;
			end
			endcase
		end
		// A frame ends any pending data byte so a lost byte cannot
		// shift every later command by one
		if (!cs_active)
			state_next = ST_CMD;
	end

	// Registers; power-up and full reset share one set of values
	always @(posedge sys_clk) begin
		if (rst || full_reset) begin
			state_reg <= ST_CMD;
			cfg_reg   <= `ACD_CFG_RESET;
			uni_reg   <= `ACD_PAIR_RESET;
			bi_reg    <= `ACD_PAIR_RESET;
			avg_reg   <= `ACD_AVG_RESET;
			conv_reg  <= `ACD_CONV_RESET;
		end else begin
			state_reg <= state_next;
			if (byte_valid) begin
				case (state_reg)
				ST_UNI_DAT: uni_reg <= byte_data;
				ST_BI_DAT:  bi_reg  <= byte_data;
				ST_CMD: begin
					case (cmd)
					CMD_SETUP: cfg_reg  <= byte_data;
					CMD_AVG:   avg_reg  <= byte_data;
					CMD_CONV:  conv_reg <= byte_data;
					default:   cfg_reg  <= cfg_reg;
					endcase
				end
				default: cfg_reg <= cfg_reg;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Derived configuration
	// ---------------------------------------------------------------
	wire [1:0] ck_mode = cfg_reg[`ACD_CLK_HI_BIT:`ACD_CLK_LO_BIT];
	wire [1:0] rf_mode = cfg_reg[`ACD_REF_HI_BIT:`ACD_REF_LO_BIT];
	wire       wake_up = (state_reg == ST_CMD) && byte_valid && (cmd == CMD_CONV);

	// Registered decode of the settings into control levels
	always @(posedge sys_clk) begin
		if (rst || full_reset) begin
			clock_mode            <= `ACD_CLK_INT_AIN;
			reference_mode        <= `ACD_REF_INT_AUTO;
			external_conv_clock   <= 1'b0;
			strobe_is_analog      <= 1'b1;
			ref_neg_is_analog     <= 1'b1;
			// Power-up reference code 00 decodes as internal and auto-off,
			// so these match the running decode and never glitch after reset
			ref_internal          <= 1'b1;
			ref_always_on         <= 1'b0;
			ref_wake_needed       <= 1'b1;
			unipolar_pairs        <= 8'h00;
			bipolar_pairs         <= 8'h00;
			pair_is_bipolar       <= 8'h00;
			averaging_active      <= 1'b0;
			repeat_single_channel <= 1'b0;
			conversion_byte       <= 8'h00;
			blocks_shutdown       <= 1'b1;
		end else begin
			clock_mode            <= ck_mode;
			reference_mode        <= rf_mode;
			external_conv_clock   <= (ck_mode == `ACD_CLK_EXT_SCLK);
			strobe_is_analog      <= ck_mode[1];
			ref_neg_is_analog     <= (rf_mode != `ACD_REF_EXT_DIFF);
			// Internal reference for codes 00 and 10
			ref_internal          <= ~rf_mode[0];
			ref_always_on         <= (rf_mode == `ACD_REF_INT_ON);
			// Only the auto-off internal reference pays the wake-up delay
			ref_wake_needed       <= (rf_mode == `ACD_REF_INT_AUTO);
			unipolar_pairs        <= uni_reg;
			bipolar_pairs         <= bi_reg;
			// Unipolar overrides; bipolar pairs report two's complement
			pair_is_bipolar       <= bi_reg & ~uni_reg;
			averaging_active      <= avg_reg[`ACD_AVG_EN_BIT] &
				(ck_mode != `ACD_CLK_EXT_SCLK);
			repeat_single_channel <= (conv_reg[2:1] == `ACD_SCAN_REPEAT);
			conversion_byte       <= conv_reg;
			// Blocks wake for a conversion request, the reference if kept on
			if (wake_up || rf_mode == `ACD_REF_INT_ON)
				blocks_shutdown <= 1'b0;
			else if (conv_done || temp_done)
				blocks_shutdown <= 1'b1;
		end
	end

	// One-cycle event outputs
	always @(posedge sys_clk) begin
		if (rst) begin
			conversion_request <= 1'b0;
			fifo_clear         <= 1'b0;
			strobe_fall        <= 1'b0;
		end else begin
			conversion_request <= wake_up;
			// Full reset also empties the result store
			fifo_clear         <= fifo_reset | full_reset;
			strobe_fall        <= ~ck_mode[1] & ~strobe_sync_reg[1] & strobe_last_reg;
		end
	end

	// ---------------------------------------------------------------
	// Result word formatting
	// ---------------------------------------------------------------
	// The internal reference scales the difference to eighth degrees,
	// so removing a fixed count converts Kelvin to Celsius
	function [11:0] temp_celsius;
		input [11:0] hi;
		input [11:0] lo;
		begin
			temp_celsius = hi - lo - `ACD_TEMP_OFFSET;
		end
	endfunction

	reg [15:0] word_reg;
	reg        load_reg;

	// Temperature result has priority when both finish together
	always @(posedge sys_clk) begin
		if (rst) begin
			word_reg <= 16'h0000;
			load_reg <= 1'b0;
		end else begin
			load_reg <= temp_done | conv_done;
			if (temp_done)
				word_reg <= {4'h0, temp_celsius(temp_high, temp_low)};
			else if (conv_done)
				// Code arrives already in binary or two's complement form
				word_reg <= {4'h0, conv_code, conv_sub};
		end
	end

	// Data out moves on falling serial edges, MSB first
	acd_shift_reg #(
		.WIDTH (`ACD_WORD_BITS)
	) u_shift (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (load_reg),
		.shift   (sclk_fall & cs_active),
		.word_in (word_reg),
		.bit_out (dout)
	);

endmodule // acd_decoder

`default_nettype wire

/* File: acd_decoder_props.sv */
/* Checker for the command byte decoder: relations between its ports.
   Assumes it is bound to acd_decoder and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module acd_decoder_props (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Watched ports
	input wire logic       convert_strobe_pin,
	input wire logic [1:0] clock_mode,
	input wire logic [1:0] reference_mode,
	input wire logic       external_conv_clock,
	input wire logic       strobe_is_analog,
	input wire logic       ref_always_on,
	input wire logic       ref_neg_is_analog,
	input wire logic [7:0] unipolar_pairs,
	input wire logic [7:0] bipolar_pairs,
	input wire logic [7:0] pair_is_bipolar,
	input wire logic       averaging_active,
	input wire logic       fifo_clear,
	input wire logic       conversion_request,
	input wire logic       blocks_shutdown,
	input wire logic       strobe_fall
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_por;
		disable iff (1'b0) rst ##1 rst |=> clock_mode == 2'h2 && strobe_is_analog
			&& unipolar_pairs == 8'h00 && bipolar_pairs == 8'h00 && blocks_shutdown;
	endproperty
	a_por: assert property (p_por) else $error("power-up state wrong");
	property p_ext;
		external_conv_clock == (clock_mode == 2'h3);
	endproperty
	a_ext: assert property (p_ext) else $error("external clock flag wrong");
	property p_stb_ain;
		strobe_is_analog == clock_mode[1];
	endproperty
	a_stb_ain: assert property (p_stb_ain) else $error("strobe role wrong");
	property p_ref_on;
		ref_always_on == (reference_mode == 2'h2);
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("reference on flag wrong");
	property p_ref_neg;
		ref_neg_is_analog == (reference_mode != 2'h3);
	endproperty
	a_ref_neg: assert property (p_ref_neg) else $error("negative ref role wrong");
	property p_pair;
		pair_is_bipolar == (bipolar_pairs & ~unipolar_pairs);
	endproperty
	a_pair: assert property (p_pair) else $error("pair polarity wrong");
	property p_avg;
		averaging_active |-> clock_mode != 2'h3;
	endproperty
	a_avg: assert property (p_avg) else $error("averaging in clock mode 11");
	property p_clr;
		fifo_clear |=> !fifo_clear;
	endproperty
	a_clr: assert property (p_clr) else $error("fifo clear longer than one cycle");
	property p_req;
		conversion_request |=> !conversion_request;
	endproperty
	a_req: assert property (p_req) else $error("conversion request too long");
	property p_stb;
		strobe_fall |-> !clock_mode[1] && $past(convert_strobe_pin, 8) == 1'b1;
	endproperty
	a_stb: assert property (p_stb) else $error("strobe pulse in analog mode");
endmodule // acd_decoder_props
bind acd_decoder acd_decoder_props u_props (.sys_clk(sys_clk), .rst(rst),
	.convert_strobe_pin(convert_strobe_pin), .clock_mode(clock_mode),
	.reference_mode(reference_mode), .external_conv_clock(external_conv_clock),
	.strobe_is_analog(strobe_is_analog), .ref_always_on(ref_always_on),
	.ref_neg_is_analog(ref_neg_is_analog), .unipolar_pairs(unipolar_pairs),
	.bipolar_pairs(bipolar_pairs), .pair_is_bipolar(pair_is_bipolar),
	.averaging_active(averaging_active), .fifo_clear(fifo_clear),
	.conversion_request(conversion_request), .blocks_shutdown(blocks_shutdown),
	.strobe_fall(strobe_fall));
`default_nettype wire

/* File: acd_spi_host.sv */
/* Serial host model: drives select, clock and data in, captures data out.
   Assumes a 25 MHz sys_clk to time its edges. */
`timescale 1ns/10ps
`default_nettype none
module acd_spi_host (
	// Timing
	input  wire logic sys_clk,
	// Serial pins
	output var logic  cs_n,
	output var logic  sclk,
	output var logic  din,
	input  wire logic dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b1;
	end
	// One frame of n bits MSB first; clock idles low outside frames
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		@(negedge sys_clk);
		cs_n = 1'b0;
		// 320 ns period stays under the external clock limit
		for (i = n - 1; i >= 0; i--) begin
			din = w[i];
			repeat (4) @(negedge sys_clk);
			sclk = 1'b1;
			repeat (4) @(negedge sys_clk);
			rx = {rx[14:0], dout};
			sclk = 1'b0;
		end
		repeat (4) @(negedge sys_clk);
		cs_n = 1'b1;
		din = ~din; // Released line must not look held
	endtask
endmodule // acd_spi_host
`default_nettype wire

/* File: acd_decoder_tb_top.sv */
/* Self-checking bench for the command byte decoder.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/10ps
`default_nettype none
`include "acd_consts.vh"
module acd_decoder_tb_top;
	logic sys_clk, rst, cs_n, sclk, din, dout, convert_strobe_pin, conv_done, temp_done;
	logic [9:0] conv_code;
	logic [1:0] conv_sub, clock_mode, reference_mode;
	logic [11:0] temp_high, temp_low;
	logic external_conv_clock, strobe_is_analog, ref_neg_is_analog, ref_internal;
	logic ref_always_on, ref_wake_needed, averaging_active, repeat_single_channel;
	logic conversion_request, fifo_clear, blocks_shutdown, strobe_fall;
	logic [7:0] unipolar_pairs, bipolar_pairs, pair_is_bipolar, conversion_byte, b, d;
	logic [15:0] rx;
	int n_fail, checks_done, cyc, n_clr, n_req, n_stb, i, k;
	int m_clk, m_ref, m_uni, m_bi, m_avg, m_conv;
	acd_decoder dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .convert_strobe_pin(convert_strobe_pin), .conv_done(conv_done),
		.conv_code(conv_code), .conv_sub(conv_sub), .temp_high(temp_high),
		.temp_low(temp_low), .temp_done(temp_done), .clock_mode(clock_mode),
		.reference_mode(reference_mode), .external_conv_clock(external_conv_clock),
		.strobe_is_analog(strobe_is_analog), .ref_neg_is_analog(ref_neg_is_analog),
		.ref_internal(ref_internal), .ref_always_on(ref_always_on),
		.ref_wake_needed(ref_wake_needed), .unipolar_pairs(unipolar_pairs),
		.bipolar_pairs(bipolar_pairs), .pair_is_bipolar(pair_is_bipolar),
		.averaging_active(averaging_active), .repeat_single_channel(repeat_single_channel),
		.conversion_byte(conversion_byte), .conversion_request(conversion_request),
		.fifo_clear(fifo_clear), .blocks_shutdown(blocks_shutdown), .strobe_fall(strobe_fall));
	acd_spi_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
	// -------------------------------------------
	// Clock, pulse counters and hang guard
	// -------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (fifo_clear === 1'b1) n_clr++;
		if (conversion_request === 1'b1) n_req++;
		if (strobe_fall === 1'b1) n_stb++;
		if (cyc == 20000) begin
			n_fail++;
			summarize;
		end
	end
	// -------------------------------------------
	// Checking tasks and reference model
	// -------------------------------------------
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task summarize;
		if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task set_pu;
		{m_clk, m_ref, m_uni, m_bi, m_avg, m_conv} = {32'd2, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
	endtask
	// Settle time covers the synchroniser and output stage
	task frame(input logic [15:0] w, input int n);
		host.xfer(w, n, rx);
		repeat (4) @(negedge sys_clk);
	endtask
	task check_cfg;
		chk("clock_mode", clock_mode, m_clk);
		chk("reference_mode", reference_mode, m_ref);
		chk("external_conv_clock", external_conv_clock, m_clk == 3);
		chk("strobe_is_analog", strobe_is_analog, m_clk >= 2);
		chk("ref_wake_needed", ref_wake_needed, m_ref == 0);
		chk("ref_always_on", ref_always_on, m_ref == 2);
		chk("ref_internal", ref_internal, m_ref % 2 == 0);
		chk("ref_neg_is_analog", ref_neg_is_analog, m_ref != 3);
		chk("unipolar_pairs", unipolar_pairs, m_uni);
		chk("bipolar_pairs", bipolar_pairs, m_bi);
		chk("pair_is_bipolar", pair_is_bipolar, m_bi & ~m_uni & 255);
		chk("averaging_active", averaging_active, m_avg && m_clk != 3);
		chk("repeat_single_channel", repeat_single_channel, m_conv / 2 % 4 == 2);
		chk("conversion_byte", conversion_byte, m_conv);
	endtask
	// -------------------------------------------
	// Main sequence
	// -------------------------------------------
	initial begin
		{rst, convert_strobe_pin, conv_done, temp_done} = 4'b1100;
		{conv_code, conv_sub, temp_high, temp_low} = '0;
		void'($urandom(70));
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		set_pu;
		check_cfg;
		chk("blocks_shutdown", blocks_shutdown, 1);
		// Every clock and reference mode, no data byte following
		for (i = 0; i < 16; i++) begin
			b = 8'h40 | i << 2 | $urandom % 2;
			frame(b, 8);
			{m_clk, m_ref} = {i / 4, i % 4};
			check_cfg;
		end
		// Pair register writes, overlapping bits included
		for (i = 0; i < 4; i++) begin
			b = 8'h42 | m_clk << 4 | m_ref << 2 | i % 2;
			d = $urandom;
			frame({b, d}, 16);
			if (i % 2) m_bi = d; else m_uni = d;
			check_cfg;
		end
		// Frame ends before the pair byte; next byte is a conversion byte
		frame(8'h42 | m_clk << 4 | m_ref << 2, 8);
		k = n_req;
		frame(8'hb4, 8);
		m_conv = 8'hb4;
		check_cfg;
		chk("conversion_request count", n_req - k, 1);
		chk("blocks_shutdown", blocks_shutdown, 0);
		// Strobe pin acts only in modes 00 and 01
		for (i = 0; i < 4; i++) begin
			frame(8'h40 | i << 4, 8);
			{m_clk, m_ref} = {i, 32'd0};
			k = n_stb;
			convert_strobe_pin = 1'b0;
			repeat (8) @(negedge sys_clk);
			convert_strobe_pin = 1'b1;
			repeat (8) @(negedge sys_clk);
			chk("strobe_fall count", n_stb - k, i < 2);
		end
		frame(8'h30, 8);
		m_avg = 1;
		check_cfg;
		frame(8'h68, 8);
		{m_clk, m_ref} = {32'd2, 32'd2};
		check_cfg;
		// Result words read out over the link
		for (i = 0; i < 4; i++) begin
			{temp_high, temp_low, conv_code, conv_sub} = {$urandom, $urandom};
			if (i % 2) conv_done = 1'b1; else temp_done = 1'b1;
			@(negedge sys_clk);
			{conv_done, temp_done} = 2'b00;
			repeat (4) @(negedge sys_clk);
			host.xfer(16'h0000, 16, rx);
			if (i % 2) chk("conv_word", rx, {4'h0, conv_code, conv_sub});
			else chk("temp_word", rx, {4'h0, temp_high - temp_low - `ACD_TEMP_OFFSET});
		end
		// FIFO clear keeps settings; full reset restores power-up
		k = n_clr;
		frame(8'h18 | $urandom % 8, 8);
		check_cfg;
		chk("fifo_clear count", n_clr - k, 1);
		frame(8'h10 | $urandom % 8, 8);
		set_pu;
		check_cfg;
		chk("blocks_shutdown", blocks_shutdown, 1);
		summarize;
	end
endmodule // acd_decoder_tb_top
`default_nettype wire
